// [inc/input_func_pkg.sv]
// Purpose: constants for the external input function handler
// Assumes: one clock, register map reached over a plain strobe port
// Notes: offsets are the setting numbers themselves; one 8-bit setting per address
// What this block does
// - servo follows its input's rising and falling edges
// - servo function needs its select equal to one
// - one home-return start per rising edge with servo on
// - home select one: arm axes; two: all axes
// - run input edges start and stop the program
// - run select two; program from execution setting
// - binary program number on ports 23 to 30
// - program number is BCD by default
// - binary mode uses port 16 as start
// - pause while pause input low in auto
// - pause leaves on cancel edge with pause high
// - pause and cancel enabled by select one
// - error reset edge clears non-cold errors
// - error reset enabled by select two
// - sixteen function selects, settings 30 to 45
// - slot port numbers from settings 283 to 298
// - moved function frees its old port
// - duplicate or non-continuous ports raise error 685
// - home slot defaults to port 31
package input_func_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int NPORT = 32;
	localparam int NSLOT = 16;
	// register offsets
	localparam logic [8:0] SEL_BASE = 9'h01E;
	localparam logic [8:0] SEL_LAST = 9'h02D;
	localparam logic [8:0] MAP_BASE = 9'h11B;
	localparam logic [8:0] MAP_LAST = 9'h12A;
	localparam logic [8:0] EXEC_PROG_ADDR = 9'h100;
	localparam logic [8:0] STATUS_ADDR = 9'h1F0;
	// status bit positions
	localparam int ST_SERVO = 0;
	localparam int ST_PAUSED = 1;
	localparam int ST_ERR685 = 2;
	localparam int ST_RUNNING = 3;
	// function slots
	localparam int SLOT_START = 0;
	localparam int SLOT_SERVO = 2;
	localparam int SLOT_RUN = 3;
	localparam int SLOT_CANCEL = 5;
	localparam int SLOT_PAUSE = 6;
	localparam int SLOT_NUM0 = 7;
	localparam int SLOT_ERR_RST = 13;
	localparam int SLOT_HOME = 15;
	// select values
	localparam logic [7:0] SEL_OFF = 8'h00;
	localparam logic [7:0] SEL_ONE = 8'h01;
	localparam logic [7:0] SEL_TWO = 8'h02;
	// reset values
	localparam logic [7:0] SEL_RESET = 8'h01;
	localparam logic [7:0] MAP_FIRST_PORT = 8'h10;
	localparam logic [7:0] EXEC_PROG_RESET = 8'h01;
	// host hold time for the run input
	localparam int RUN_HOLD_MS = 100;
endpackage

// [design/input_func_handler.sv]
// Purpose: external input ports mapped onto servo, home, run, pause and error-reset functions
// Assumes: inputs may be asynchronous to clk, two-flop synchroniser; host keeps its own timing duties
// Notes: all outputs registered; pulses last one cycle
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module input_func_handler
	import input_func_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	// physical input ports and mode
	input wire logic [NPORT-1:0] in_port,
	input wire logic auto_mode,
	// to motion, program and error subsystems
	output logic servo_on,
	output logic home_req,
	output logic home_all,
	output logic run_start,
	output logic run_stop,
	output logic [7:0] prog_num,
	output logic paused,
	output logic err_reset,
	output logic err_685,
	output logic [NPORT-1:0] gp_in
);
	logic [7:0] fsel [NSLOT];
	logic [7:0] fmap [NSLOT];
	logic [7:0] exec_prog;
	logic [NPORT-1:0] in_meta;
	logic [NPORT-1:0] in_sync;
	logic [NPORT-1:0] in_last;
	logic [NSLOT-1:0] slot_now;
	logic [NSLOT-1:0] slot_old;
	logic [NSLOT-1:0] slot_rise;
	logic [NSLOT-1:0] slot_fall;
	logic [NPORT-1:0] claimed;
	logic map_bad;
	logic running;

	// address decode
	wire sel_hit = (addr >= SEL_BASE) && (addr <= SEL_LAST);
	wire map_hit = (addr >= MAP_BASE) && (addr <= MAP_LAST);
	wire [3:0] sel_idx = 4'(addr - SEL_BASE);
	wire [3:0] map_idx = 4'(addr - MAP_BASE);

	// synchroniser; only in_sync and in_last feed edge logic
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			in_meta <= '0;
			in_sync <= '0;
			in_last <= '0;
		end else begin
			in_meta <= in_port;
			in_sync <= in_meta;
			in_last <= in_sync;
		end
	end

	// each slot reads the port named by its map setting
	genvar g;
	generate
		for (g = 0; g < NSLOT; g++) begin : g_slot
			wire in_range = fmap[g] < 8'(NPORT);
			wire [4:0] pidx = fmap[g][4:0];
			assign slot_now[g] = in_range && in_sync[pidx];
			assign slot_old[g] = in_range && in_last[pidx];
			assign slot_rise[g] = slot_now[g] && !slot_old[g] && !map_bad;
			assign slot_fall[g] = !slot_now[g] && slot_old[g] && !map_bad;
		end
	endgenerate

	// map checks and the set of ports held by functions whose select is not zero
	always_comb begin
		map_bad = 1'b0;
		claimed = '0;
		for (int i = 0; i < NSLOT; i++) begin
			if (fmap[i] >= 8'(NPORT))
				map_bad = 1'b1;
			else if (fsel[i] != SEL_OFF)
				claimed[fmap[i][4:0]] = 1'b1;
			if (i > 0 && fmap[i] != fmap[i-1] + 8'h01)
				map_bad = 1'b1; // continuity also rules out duplicates
		end
	end

	// function enables
	wire servo_en = fsel[SLOT_SERVO] == SEL_ONE;
	wire run_en = fsel[SLOT_RUN] == SEL_TWO;
	wire bin_mode = fsel[SLOT_START] == SEL_TWO;
	wire start_en = fsel[SLOT_START] != SEL_OFF;
	wire pause_en = fsel[SLOT_PAUSE] == SEL_ONE;
	wire cancel_en = fsel[SLOT_CANCEL] == SEL_ONE;
	wire erst_en = fsel[SLOT_ERR_RST] == SEL_TWO;
	wire home_sel1 = fsel[SLOT_HOME] == SEL_ONE;
	wire home_sel2 = fsel[SLOT_HOME] == SEL_TWO;

	// program number from the eight number slots
	wire [7:0] num_raw = slot_now[SLOT_NUM0 +: 8];
	wire [7:0] bcd_val = 8'({num_raw[7:4], 3'b000}) + 8'({num_raw[7:4], 1'b0}) + 8'(num_raw[3:0]);
	wire [7:0] sel_num = bin_mode ? num_raw : bcd_val;

	// next values of the function state
	wire next_pause_set = pause_en && auto_mode && !slot_now[SLOT_PAUSE] && !map_bad;
	wire pause_clr = cancel_en && slot_rise[SLOT_CANCEL] && slot_now[SLOT_PAUSE];
	wire start_hit = start_en && slot_rise[SLOT_START];
	wire run_hit = run_en && slot_rise[SLOT_RUN];

	// registers written by software
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NSLOT; i++) begin
				fsel[i] <= SEL_RESET;
				fmap[i] <= MAP_FIRST_PORT + 8'(i); // slot 15 lands on port 31
			end
			exec_prog <= EXEC_PROG_RESET;
		end else if (wr) begin
			if (sel_hit)
				fsel[sel_idx] <= wdata;
			if (map_hit)
				fmap[map_idx] <= wdata;
			if (addr == EXEC_PROG_ADDR)
				exec_prog <= wdata;
		end
	end

	// function outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			servo_on <= 1'b0;
			home_req <= 1'b0;
			home_all <= 1'b0;
			run_start <= 1'b0;
			run_stop <= 1'b0;
			prog_num <= 8'h00;
			paused <= 1'b0;
			err_reset <= 1'b0;
			err_685 <= 1'b0;
			running <= 1'b0;
		end else begin
			if (servo_en && slot_rise[SLOT_SERVO])
				servo_on <= 1'b1;
			else if (servo_en && slot_fall[SLOT_SERVO])
				servo_on <= 1'b0;
			// home only honoured with servo on; gated here by servo_on
			home_req <= (home_sel1 || home_sel2) && slot_rise[SLOT_HOME] && servo_on;
			if (slot_rise[SLOT_HOME])
				home_all <= home_sel2;
			run_start <= run_hit || start_hit;
			run_stop <= run_en && slot_fall[SLOT_RUN];
			if (run_hit)
				prog_num <= exec_prog;
			else if (start_hit)
				prog_num <= sel_num;
			if (run_hit || start_hit)
				running <= 1'b1;
			else if (run_en && slot_fall[SLOT_RUN])
				running <= 1'b0;
			// set wins over the cancel edge
			if (next_pause_set)
				paused <= 1'b1;
			else if (pause_clr)
				paused <= 1'b0;
			err_reset <= erst_en && slot_rise[SLOT_ERR_RST];
			err_685 <= map_bad;
		end
	end

	// general-purpose view and read port
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gp_in <= '0;
			rdata <= 8'h00;
		end else begin
			gp_in <= in_sync & ~claimed;
			if (!rd)
				rdata <= 8'h00;
			else if (sel_hit)
				rdata <= fsel[sel_idx];
			else if (map_hit)
				rdata <= fmap[map_idx];
			else if (addr == EXEC_PROG_ADDR)
				rdata <= exec_prog;
			else if (addr == STATUS_ADDR)
				rdata <= {4'h0, running, err_685, paused, servo_on};
			else
				rdata <= 8'h00; // unmapped reads as zero
		end
	end
endmodule // input_func_handler

// [bench/host_model.sv]
// Purpose: host that drives the physical input ports
// Assumes: req holds the levels the bench wants
// Notes: one cycle of output latency, like a real output stage
`timescale 1ns/1ps
module host_model #(parameter int HOLD = 4) (
	// clock, reset and wanted levels
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [31:0] req,
	// physical ports
	output logic [31:0] in_port
);
	logic [7:0] held;
	// home waits for servo, run input is never dropped early
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			in_port <= 32'h0000_0000;
			held <= 8'h00;
		end else begin
			held <= in_port[19] ? held + 8'h01 : 8'h00;
			in_port <= req;
			in_port[31] <= req[31] & in_port[18];
			if (!req[19] && held < 8'(HOLD)) in_port[19] <= in_port[19];
		end
	end
endmodule // host_model

// [bench/input_func_props.sv]
// Purpose: port checks of the input handler
// Assumes: the bench keeps the live slot map on its default ports
// Notes: each function result must trace back to a port edge three samples earlier
`timescale 1ns/1ps
module input_func_props (
	// clock, reset and bus
	input wire logic clk,
	input wire logic rst_b,
	input wire logic rd,
	input wire logic [7:0] rdata,
	// ports and results
	input wire logic [31:0] in_port,
	input wire logic servo_on,
	input wire logic home_req,
	input wire logic run_start,
	input wire logic run_stop,
	input wire logic paused,
	input wire logic err_reset,
	input wire logic [31:0] gp_in
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_servo_rise: assert property ($rose(servo_on) |->
		$past(in_port[18], 3) && !$past(in_port[18], 4)) else $error("servo on without edge");
	a_home_edge: assert property (home_req |->
		$past(in_port[31], 3) && !$past(in_port[31], 4)) else $error("home without edge");
	a_run_begin: assert property (run_start |->
		($past(in_port[19], 3) && !$past(in_port[19], 4)) ||
		($past(in_port[16], 3) && !$past(in_port[16], 4))) else $error("start without edge");
	a_run_end: assert property (run_stop |->
		!$past(in_port[19], 3) && $past(in_port[19], 4)) else $error("stop without edge");
	a_err_clear: assert property (err_reset |->
		$past(in_port[29], 3) && !$past(in_port[29], 4)) else $error("error reset without edge");
	a_pause_leave: assert property ($fell(paused) |-> $past(in_port[22], 3) &&
		$past(in_port[21], 3) && !$past(in_port[21], 4)) else $error("pause left too early");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("stray read data");
	a_gp_free: assert property (gp_in[15:0] == $past(in_port[15:0], 3))
		else $error("free port not passed");
	c_home: cover property (home_req);
	c_resume: cover property ($fell(paused));
	c_start: cover property (run_start);
endmodule // input_func_props
bind input_func_handler input_func_props i_props (.*);

// [bench/input_func_handler_tb.sv]
// Purpose: self-checking bench of the input handler
// Assumes: host model adds one cycle before the ports
// Notes: results are sampled in the cycle they stand
`timescale 1ns/1ps
module input_func_handler_tb;
	import input_func_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic auto_mode = 1'b0;
	logic [8:0] addr = 9'h000;
	logic [7:0] wdata = 8'h00;
	logic [31:0] req = 32'h0000_0000;
	logic [7:0] rdata, prog_num, d;
	logic [31:0] in_port, gp_in;
	logic servo_on, home_req, home_all, run_start, run_stop, paused, err_reset, err_685;
	int num_errors = 0;
	int num_checks = 0;
	// reset values plus an unmapped hole
	logic [16:0] rows [7] = '{{9'h01E, 8'h01}, {9'h02D, 8'h01}, {9'h11B, 8'h10},
		{9'h12A, 8'h1F}, {9'h100, 8'h01}, {9'h050, 8'h00}, {9'h1F0, 8'h00}};
	host_model #(.HOLD(4)) i_host (.clk(clk), .rst_b(rst_b), .req(req), .in_port(in_port));
	input_func_handler i_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .in_port(in_port), .auto_mode(auto_mode), .servo_on(servo_on),
		.home_req(home_req), .home_all(home_all), .run_start(run_start), .run_stop(run_stop),
		.prog_num(prog_num), .paused(paused), .err_reset(err_reset), .err_685(err_685),
		.gp_in(gp_in));
	always #2.5 clk = ~clk;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wreg(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [8:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// flip host levels, then wait out host stage plus sync and output flop
	task automatic tog(input logic [31:0] m);
		@(posedge clk);
		req <= req ^ m;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// watchdog, far beyond the roughly 110 cycles the tests need
	initial begin
		#100us;
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			rreg(rows[i][16:8], d);
			chk("reg", rows[i][7:0], d);
		end
		tog(32'h0004_0020);
		chk("servo", 1, servo_on);
		chk("gp", 32'h0000_0020, gp_in);
		wreg(9'h02D, SEL_TWO);
		tog(32'h8000_0000);
		chk("home", 1, home_req);
		chk("home_all", 1, home_all);
		tog(32'h8004_0000);
		chk("servo off", 0, servo_on);
		wreg(9'h021, SEL_TWO);
		wreg(EXEC_PROG_ADDR, 8'h05);
		tog(32'h0008_0000);
		chk("run", 1, run_start);
		chk("exec prog", 8'h05, prog_num);
		repeat (6) @(posedge clk);
		tog(32'h0008_0000);
		chk("stop", 1, run_stop);
		tog(32'h1280_0000);
		tog(32'h0001_0000);
		chk("bcd", 8'h19, prog_num);
		tog(32'h0001_0000);
		wreg(9'h01E, SEL_TWO);
		tog(32'h0001_0000);
		chk("bin start", 1, run_start);
		chk("bin", 8'h25, prog_num);
		auto_mode <= 1'b1;
		repeat (5) @(posedge clk);
		chk("pause", 1, paused);
		tog(32'h0040_0000);
		chk("still paused", 1, paused);
		tog(32'h0020_0000);
		chk("resumed", 0, paused);
		wreg(9'h02B, SEL_TWO);
		tog(32'h2000_0000);
		chk("err reset", 1, err_reset);
		wreg(9'h11B, 8'h11);
		rreg(STATUS_ADDR, d);
		chk("map err", 1, d[ST_ERR685]);
		give_verdict();
	end
endmodule // input_func_handler_tb
